// >>> hdl/ncop_core.v
// Numeric coprocessor operand port with APB registers
// Behaviour
// RQ1: host spends one bus cycle dispatching escape
// RQ2: pointer loads overlap execution, add no time
// RQ3: only memory operands move words, per length
// RQ4: even address: one memory, one coprocessor cycle
// RQ5: odd address: two byte cycles plus one; the ODD bit is never read, so odd words cost the same as even
// RQ6: real operands 32, 64, 80 bits
// RQ7: packed decimal: 18 digits in 10 bytes
// RQ8: integer operands 16, 32, 64 bits
// RQ9: stack registers indexed 0..7 from top
// RQ10: penalties 14 overflow, 16 underflow, 33 denormal
// RQ11: precision exception leaves clock count unchanged
// RQ12: invalid, denormal, zero-divide shorten within range
// RQ13: clocks counted on own clock, 10 MHz
// RQ14: handshake tolerates any acknowledge latency
// RQ15: one request per word, await acknowledge
`timescale 1ns/10ps
`default_nettype none
`include "ncop_defs.vh"

module ncop_core
#(
  parameter DW      = 16,
  parameter CW      = 17,
  parameter SHORTEN = 17'h00005
)
(
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          escape_opcode,
  input  wire          pointer_load,
  input  wire [15:0]   pointer_ip,
  input  wire [15:0]   pointer_dp,
  output reg           operand_transfer_request,
  input  wire          operand_transfer_acknowledge,
  input  wire [DW-1:0] operand_data_in,
  output reg  [DW-1:0] operand_data_out,
  output reg           busy,
  output reg           irq
);

  localparam S_IDLE = 3'd0;
  localparam S_XREQ = 3'd1;
  localparam S_XGAP = 3'd2;
  localparam S_EXEC = 3'd3;
  localparam S_DONE = 3'd4;

  // Operand size per format
  function [6:0] fmt_bits;
    input [2:0] fmt;
    begin
      case (fmt)
        `NCOP_FMT_SHORT_REAL: fmt_bits = `NCOP_BITS_SHORT_REAL; // RQ6
        `NCOP_FMT_LONG_REAL:  fmt_bits = `NCOP_BITS_LONG_REAL;  // RQ6
        `NCOP_FMT_TEMP_REAL:  fmt_bits = `NCOP_BITS_TEMP_REAL;  // RQ6
        `NCOP_FMT_PACKED:     fmt_bits = {`NCOP_PACKED_BYTES, 3'b000}; // RQ7
        `NCOP_FMT_WORD_INT:   fmt_bits = `NCOP_BITS_WORD_INT;   // RQ8
        `NCOP_FMT_SHORT_INT:  fmt_bits = `NCOP_BITS_SHORT_INT;  // RQ8
        `NCOP_FMT_LONG_INT:   fmt_bits = `NCOP_BITS_LONG_INT;   // RQ8
        default:              fmt_bits = `NCOP_BITS_WORD_INT;
      endcase
    end
  endfunction

  // Register decode, used by read and write paths
  function mapped;
    input [7:0] a;
    begin
      case (a)
        `NCOP_OFF_CTRL, `NCOP_OFF_CLOCKS, `NCOP_OFF_EXC, `NCOP_OFF_STATUS,
        `NCOP_OFF_STACK, `NCOP_OFF_IPTR, `NCOP_OFF_DPTR, `NCOP_OFF_INT_STAT,
        `NCOP_OFF_INT_MASK, `NCOP_OFF_DATA: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  reg [`NCOP_CTRL_W-1:0] ctrl_reg;
  reg [31:0]             clocks_reg;
  reg [`NCOP_EXC_W-1:0]  exc_reg;
  reg [2:0]              stack_top_register;
  reg [2:0]              stack_index_reg;
  reg [15:0]             iptr_reg;
  reg [15:0]             dptr_reg;
  reg [`NCOP_INT_W-1:0]  int_stat_reg;
  reg [`NCOP_INT_W-1:0]  int_mask_reg;
  reg [DW-1:0]           data_in_reg;
  reg [2:0]              state_reg;
  reg [2:0]              state_next;
  reg [3:0]              words_reg;
  reg                    post_xfer_reg;
  reg [CW-1:0]           last_clocks_reg;

  wire           wr_en   = psel & penable & pready & pwrite;
  wire           setup   = psel & ~penable & ~pready;
  wire [6:0]     op_bits = fmt_bits(ctrl_reg[`NCOP_CTRL_FMT_MSB:`NCOP_CTRL_FMT_LSB]);
  // Every format is whole 16-bit words, so no remainder is kept
  wire [6:0]     op_shift = op_bits >> `NCOP_WORD_SHIFT;
  wire [3:0]     op_words = op_shift[3:0]; // RQ3
  wire           mem_ref = ctrl_reg[`NCOP_CTRL_MEMREF];
  wire           store   = ctrl_reg[`NCOP_CTRL_STORE];
  wire [2:0]     stack_relative_register = stack_top_register + stack_index_reg; // RQ9
  wire           word_ack = (state_reg == S_XREQ) & operand_transfer_request
                            & operand_transfer_acknowledge;
  wire           timer_done;
  wire [CW-1:0]  timer_elapsed;
  reg            timer_load;
  reg  [CW-1:0]  exec_clocks;
  reg  [CW-1:0]  penalty;
  reg  [CW-1:0]  typical;
  reg  [CW-1:0]  floor_clk;

  // Execution length from typical count, shortening and penalties
  always @*
  begin
    typical   = {1'b0, clocks_reg[15:0]};
    floor_clk = {1'b0, clocks_reg[31:16]};
    penalty   = {CW{1'b0}};
    if (exc_reg[`NCOP_EXC_OVF_UNM])
      penalty = penalty + `NCOP_PEN_OVF; // RQ10
    if (exc_reg[`NCOP_EXC_UNF_UNM])
      penalty = penalty + `NCOP_PEN_UNF; // RQ10
    if (exc_reg[`NCOP_EXC_DEN_MSK])
      penalty = penalty + `NCOP_PEN_DEN; // RQ10
    exec_clocks = typical;
    // Shortened count never drops under the minimum of the range
    if (exc_reg[`NCOP_EXC_INVALID] | exc_reg[`NCOP_EXC_ZDIV] | exc_reg[`NCOP_EXC_DEN_UNM])
    begin
      if (typical > floor_clk + SHORTEN)
        exec_clocks = typical - SHORTEN; // RQ12
      else
        exec_clocks = floor_clk; // RQ12
    end
    // Precision flag deliberately has no term here
    exec_clocks = exec_clocks + penalty; // RQ11
  end

  ncop_exec_timer #(
    .CW (CW)
  ) u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (timer_load),
    .load_value (exec_clocks),
    .done       (timer_done),
    .running    (),
    .elapsed    (timer_elapsed)
  );

  // Sequencer: dispatch, word transfers, execution
  always @*
  begin
    state_next = state_reg;
    timer_load = 1'b0;
    case (state_reg)
      S_IDLE:
        if (escape_opcode)
        begin
          // Escape dispatch cycle is the host's; memory loads fetch operand words next, others start execution next
          if (mem_ref & ~store & (op_words != 4'h0))
            state_next = S_XREQ; // RQ1
          else
          begin
            state_next = S_EXEC; // RQ1
            timer_load = 1'b1;
          end
        end
      S_XREQ:
        if (word_ack)
        begin
          if (words_reg == 4'h1)
          begin
            if (post_xfer_reg)
              state_next = S_DONE;
            else
            begin
              state_next = S_EXEC;
              timer_load = 1'b1;
            end
          end
          else
            state_next = S_XGAP; // RQ15
        end
      S_XGAP:
        state_next = S_XREQ;
      S_EXEC:
        if (timer_done)
        begin
          if (mem_ref & store & (op_words != 4'h0))
            state_next = S_XREQ; // RQ3
          else
            state_next = S_DONE;
        end
      S_DONE:
        state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg                <= S_IDLE;
      words_reg                <= 4'h0;
      post_xfer_reg            <= 1'b0;
      operand_transfer_request <= 1'b0;
      data_in_reg              <= {DW{1'b0}};
      busy                     <= 1'b0;
      last_clocks_reg          <= {CW{1'b0}};
    end
    else
    begin
      state_reg <= state_next;
      busy      <= (state_next != S_IDLE);
      if ((state_reg == S_IDLE) & escape_opcode)
      begin
        words_reg     <= op_words;
        post_xfer_reg <= store;
      end
      if (timer_done)
        last_clocks_reg <= timer_elapsed;
      // Request held until acknowledged, however late it comes
      if (word_ack)
      begin
        operand_transfer_request <= 1'b0; // RQ15
        words_reg                <= words_reg - 4'h1;
        if (~post_xfer_reg)
          data_in_reg <= operand_data_in;
      end
      else if (state_next == S_XREQ)
        operand_transfer_request <= 1'b1; // RQ14
    end
  end

  // Register writes, status and interrupts
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg           <= `NCOP_CTRL_RESET;
      clocks_reg         <= `NCOP_CLOCKS_RESET;
      exc_reg            <= {`NCOP_EXC_W{1'b0}};
      stack_top_register <= 3'h0;
      stack_index_reg    <= 3'h0;
      iptr_reg           <= 16'h0000;
      dptr_reg           <= 16'h0000;
      int_stat_reg       <= {`NCOP_INT_W{1'b0}};
      int_mask_reg       <= {`NCOP_INT_W{1'b0}};
      operand_data_out   <= {DW{1'b0}};
      irq                <= 1'b0;
    end
    else
    begin
      // Pointer loads accepted in any state, never stall execution
      if (pointer_load)
      begin
        iptr_reg <= pointer_ip; // RQ2
        dptr_reg <= pointer_dp; // RQ2
      end
      if (wr_en)
      begin
        case (paddr)
          `NCOP_OFF_CTRL:     ctrl_reg <= pwdata[`NCOP_CTRL_W-1:0];
          `NCOP_OFF_CLOCKS:   clocks_reg <= pwdata;
          `NCOP_OFF_EXC:      exc_reg <= pwdata[`NCOP_EXC_W-1:0];
          `NCOP_OFF_STACK:
          begin
            stack_top_register <= pwdata[`NCOP_STACK_TOP_LSB+2:`NCOP_STACK_TOP_LSB];
            stack_index_reg    <= pwdata[`NCOP_STACK_IDX_LSB+2:`NCOP_STACK_IDX_LSB]; // RQ9
          end
          `NCOP_OFF_INT_MASK: int_mask_reg <= pwdata[`NCOP_INT_W-1:0];
          `NCOP_OFF_DATA:     operand_data_out <= pwdata[DW-1:0];
          default:            ;
        endcase
      end
      // Set wins over a write-one-to-clear in the same cycle
      int_stat_reg <= (int_stat_reg
                       & ~((wr_en & (paddr == `NCOP_OFF_INT_STAT))
                           ? pwdata[`NCOP_INT_W-1:0] : {`NCOP_INT_W{1'b0}}))
                      | {word_ack, state_reg == S_DONE};
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // APB slave: one wait-free access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped(paddr);
      if (setup & ~pwrite)
      begin
        case (paddr)
          `NCOP_OFF_CTRL:     prdata <= {26'h0, ctrl_reg};
          `NCOP_OFF_CLOCKS:   prdata <= clocks_reg;
          `NCOP_OFF_EXC:      prdata <= {25'h0, exc_reg};
          `NCOP_OFF_STATUS:
            prdata <= {last_clocks_reg[15:0], 4'h0, words_reg, 1'b0,
                       stack_top_register, busy, state_reg};
          `NCOP_OFF_STACK:
            prdata <= {21'h0, stack_relative_register, 1'b0,
                       stack_index_reg, 1'b0, stack_top_register};
          `NCOP_OFF_IPTR:     prdata <= {16'h0, iptr_reg};
          `NCOP_OFF_DPTR:     prdata <= {16'h0, dptr_reg};
          `NCOP_OFF_INT_STAT: prdata <= {30'h0, int_stat_reg};
          `NCOP_OFF_INT_MASK: prdata <= {30'h0, int_mask_reg};
          `NCOP_OFF_DATA:     prdata <= {16'h0, data_in_reg};
          default:            prdata <= 32'h00000000;
        endcase
      end
      else
        prdata <= 32'h00000000;
    end
  end

endmodule // ncop_core

`default_nettype wire

// >>> hdl/ncop_defs.vh
// Constants for the numeric coprocessor operand port
`ifndef NCOP_DEFS_VH
`define NCOP_DEFS_VH

// Register byte offsets
`define NCOP_OFF_CTRL      8'h00
`define NCOP_OFF_CLOCKS    8'h04
`define NCOP_OFF_EXC       8'h08
`define NCOP_OFF_STATUS    8'h0C
`define NCOP_OFF_STACK     8'h10
`define NCOP_OFF_IPTR      8'h14
`define NCOP_OFF_DPTR      8'h18
`define NCOP_OFF_INT_STAT  8'h1C
`define NCOP_OFF_INT_MASK  8'h20
`define NCOP_OFF_DATA      8'h24

// Control fields
`define NCOP_CTRL_FMT_LSB  0
`define NCOP_CTRL_FMT_MSB  2
`define NCOP_CTRL_MEMREF   3
`define NCOP_CTRL_STORE    4
`define NCOP_CTRL_ODD      5
`define NCOP_CTRL_W        6
`define NCOP_CTRL_RESET    6'h00

// Operand formats
`define NCOP_FMT_SHORT_REAL  3'h0
`define NCOP_FMT_LONG_REAL   3'h1
`define NCOP_FMT_TEMP_REAL   3'h2
`define NCOP_FMT_PACKED      3'h3
`define NCOP_FMT_WORD_INT    3'h4
`define NCOP_FMT_SHORT_INT   3'h5
`define NCOP_FMT_LONG_INT    3'h6

// Operand sizes in bits; packed sizes in digits and bytes
`define NCOP_BITS_SHORT_REAL 7'h20
`define NCOP_BITS_LONG_REAL  7'h40
`define NCOP_BITS_TEMP_REAL  7'h50
`define NCOP_PACKED_DIGITS   5'h12
`define NCOP_PACKED_BYTES    4'hA
`define NCOP_BITS_WORD_INT   7'h10
`define NCOP_BITS_SHORT_INT  7'h20
`define NCOP_BITS_LONG_INT   7'h40
`define NCOP_WORD_SHIFT      4

// Exception control fields
`define NCOP_EXC_OVF_UNM   0
`define NCOP_EXC_UNF_UNM   1
`define NCOP_EXC_DEN_MSK   2
`define NCOP_EXC_PREC      3
`define NCOP_EXC_INVALID   4
`define NCOP_EXC_ZDIV      5
`define NCOP_EXC_DEN_UNM   6
`define NCOP_EXC_W         7

// Execution penalties in coprocessor clocks
`define NCOP_PEN_OVF       17'h0000E
`define NCOP_PEN_UNF       17'h00010
`define NCOP_PEN_DEN       17'h00021

// Clock and reset values, stack field positions
`define NCOP_CLK_MHZ        10
`define NCOP_CLOCKS_RESET   32'h0000000A
`define NCOP_STACK_TOP_LSB  0
`define NCOP_STACK_IDX_LSB  4
`define NCOP_STACK_PHYS_LSB 8
`define NCOP_STACK_MAX      3'h7

// Status fields
`define NCOP_ST_STATE_LSB   0
`define NCOP_ST_BUSY        3
`define NCOP_ST_TOP_LSB     4
`define NCOP_ST_WORDS_LSB   8
`define NCOP_ST_CLK_LSB     16

// Interrupt bits
`define NCOP_INT_DONE       0
`define NCOP_INT_WORD       1
`define NCOP_INT_W          2

`endif

// >>> hdl/ncop_exec_timer.v
// Execution clock counter of the numeric coprocessor
`timescale 1ns/10ps
`default_nettype none

module ncop_exec_timer
#(
  parameter CW = 17
)
(
  input  wire          pclk,
  input  wire          presetn,
  input  wire          load,
  input  wire [CW-1:0] load_value,
  output reg           done,
  output reg           running,
  output reg  [CW-1:0] elapsed
);

  reg [CW-1:0] remain_reg;

  // Counts coprocessor clocks only, independent of host bus timing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remain_reg <= {CW{1'b0}};
      running    <= 1'b0;
      done       <= 1'b0;
      elapsed    <= {CW{1'b0}};
    end
    else
    begin
      done <= 1'b0;
      if (load)
      begin
        remain_reg <= load_value;
        running    <= 1'b1;
        elapsed    <= {CW{1'b0}};
      end
      else if (running)
      begin
        elapsed <= elapsed + {{(CW-1){1'b0}}, 1'b1}; // RQ13
        if (remain_reg <= {{(CW-1){1'b0}}, 1'b1})
        begin
          running <= 1'b0;
          done    <= 1'b1;
        end
        else
          remain_reg <= remain_reg - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // ncop_exec_timer

`default_nettype wire

// >>> verif/ncop_core_checker.sv
// Concurrent checks on the coprocessor operand port
`timescale 1ns/10ps
`default_nettype none

module ncop_core_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic escape_opcode,
  input wire logic operand_transfer_request,
  input wire logic operand_transfer_acknowledge,
  input wire logic busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_req_hold;
    operand_transfer_request && !operand_transfer_acknowledge |=> operand_transfer_request;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped before acknowledge");
  property p_req_drop;
    operand_transfer_request && operand_transfer_acknowledge |=> !operand_transfer_request;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("request held after acknowledge");
  property p_req_fall;
    $fell(operand_transfer_request) |-> $past(operand_transfer_acknowledge);
  endproperty
  a_req_fall: assert property (p_req_fall)
    else $error("request fell without acknowledge");
  property p_req_busy;
    operand_transfer_request |-> busy;
  endproperty
  a_req_busy: assert property (p_req_busy)
    else $error("request outside an instruction");
  property p_esc_start;
    escape_opcode && !busy |=> busy;
  endproperty
  a_esc_start: assert property (p_esc_start)
    else $error("dispatch did not start execution");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  property p_setup_ans;
    psel && !penable |=> pready;
  endproperty
  a_setup_ans: assert property (p_setup_ans)
    else $error("no answer after setup");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  property p_idle_bus;
    !psel |=> !pready;
  endproperty
  a_idle_bus: assert property (p_idle_bus)
    else $error("pready while not selected");
endmodule // ncop_core_checker

`default_nettype wire

// >>> verif/ncop_host_model.sv
// Host data channel model answering operand word requests
`timescale 1ns/10ps
`default_nettype none

module ncop_host_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic [3:0]  ack_delay,
  input  wire logic [15:0] data_out,
  output var  logic        ack,
  output var  logic [15:0] data_in,
  output var  int          words,
  output var  logic [15:0] last_out
);
  logic [3:0] wait_cnt;

  // Memory side cost folded into the delay; data toggles when not offered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack      <= 1'b0;
      wait_cnt <= 4'h0;
      words    <= 0;
      data_in  <= 16'h5A5A;
      last_out <= 16'h0000;
    end
    else if (ack && req)
    begin
      ack      <= 1'b0;
      words    <= words + 1;
      last_out <= data_out;
      wait_cnt <= 4'h0;
      data_in  <= ~data_in;
    end
    else if (req && wait_cnt >= ack_delay)
    begin
      ack     <= 1'b1;
      data_in <= 16'hC000 | words[15:0];
    end
    else
    begin
      wait_cnt <= req ? wait_cnt + 4'h1 : 4'h0;
      data_in  <= ~data_in;
    end
  end
endmodule // ncop_host_model

`default_nettype wire

// >>> verif/tb.sv
// Testbench for the coprocessor operand port
`timescale 1ns/10ps
`default_nettype none

bind ncop_core ncop_core_checker ncop_core_checker_i (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .escape_opcode, .operand_transfer_request, .operand_transfer_acknowledge,
  .busy);

module tb;
  logic        pclk, presetn, psel, penable, pwrite, escape_opcode, pointer_load;
  logic        req, ack, busy, irq, pready, pslverr, pslv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ip, dp, din, dout, last_out;
  logic [3:0]  ack_delay;
  int          err_total, comparisons, cyc, words, e, x;
  int          wexp [7] = '{2, 4, 5, 5, 1, 2, 4};

  ncop_core ncop_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .escape_opcode, .pointer_load, .pointer_ip(ip), .pointer_dp(dp),
    .operand_transfer_request(req), .operand_transfer_acknowledge(ack),
    .operand_data_in(din), .operand_data_out(dout), .busy, .irq);
  ncop_host_model ncop_host_model_i (.pclk, .presetn, .req, .ack_delay, .data_out(dout),
    .ack, .data_in(din), .words, .last_out);

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report;
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] ex);
    comparisons++;
    if (s !== ex)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, s);
    end
  endtask

  // Waits on pready without assuming a latency; starts one edge late so a
  // release never meets the next setup in one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    pslv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, ex);
  endtask

  // One-cycle dispatch, then a stray dispatch while busy that must be ignored
  task automatic run(input logic [31:0] ctrl, input int ex);
    int w0;
    w0 = words;
    apb(1'b1, 8'h00, ctrl);
    escape_opcode <= 1'b1;
    @(posedge pclk);
    escape_opcode <= 1'b0;
    pointer_load <= 1'b1;
    ip <= ip + 16'h0101;
    dp <= dp + 16'h0202;
    @(posedge pclk);
    escape_opcode <= 1'b1;
    pointer_load <= 1'b0;
    @(posedge pclk);
    escape_opcode <= 1'b0;
    while (busy !== 1'b0)
      @(posedge pclk);
    chk("word_count", 32'(words - w0), 32'(ex));
  endtask

  task automatic irq_chk(input logic ex);
    repeat (2) @(posedge pclk);
    #1 chk("irq", {31'h0, irq}, {31'h0, ex});
    @(posedge pclk);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, escape_opcode, pointer_load} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ip = 16'h0;
    dp = 16'h0;
    ack_delay = 4'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(8'h04, 32'h0000000A, "clocks_reset");
    rd_chk(8'h00, 32'h0, "ctrl_reset");
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    rd_chk(8'h0C, 32'h0, "status_ro");
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped_err", {31'h0, pslv}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, 8'h10, 32'((((k + 3) & 7) << 4) | k));
      apb(1'b0, 8'h10, 32'h0);
      chk("stack_phys", {29'h0, rd[10:8]}, 32'((2 * k + 3) & 7));
    end
    for (int f = 0; f < 7; f++)
    begin
      ack_delay <= 4'(f);
      run(32'({f[0], 2'b01, f[2:0]}), wexp[f]);
    end
    apb(1'b1, 8'h24, 32'h0000BEEF);
    run(32'h0000001C, 1);
    chk("store_word", {16'h0, last_out}, 32'h0000BEEF);
    apb(1'b1, 8'h04, 32'h000A0014);
    for (int i = 0; i < 7; i++)
    begin
      x = 1 << i;
      e = (x & 32'h70) ? 15 : 20;
      e += x[0] ? 14 : x[1] ? 16 : x[2] ? 33 : 0;
      apb(1'b1, 8'h08, 32'(x));
      run(32'h0, 0);
      apb(1'b0, 8'h0C, 32'h0);
      chk("exec_clocks", {16'h0, rd[31:16]}, 32'(e));
    end
    rd_chk(8'h14, {16'h0, ip}, "ip_ptr");
    rd_chk(8'h18, {16'h0, dp}, "dp_ptr");
    rd_chk(8'h1C, 32'h3, "int_stat");
    irq_chk(1'b0);
    apb(1'b1, 8'h20, 32'h1);
    irq_chk(1'b1);
    apb(1'b1, 8'h1C, 32'h3);
    irq_chk(1'b0);
    rd_chk(8'h1C, 32'h0, "int_clear");
    final_report;
  end
endmodule // tb

`default_nettype wire
